/* rtl/bdi_defs.svh */
// Constants of the block-transfer device interface: register indices,
// field positions, status encodings and switch widths.
// Assumes inclusion by bare name from the top module, the checker and the bench.
//
// Contract
// [R1] Writing a direction's end register starts its transfer from the loaded begin address.
// [R2] End bit 15 set only if no error and this buffer was the final one.
// [R3] End bit 0 flags reinit, bus abort, read while active, or device fault.
// [R4] End bits 12:1 hold address of last word moved, modulo 4096.
// [R5] Pointer's top seven bits come from begin and never change: 8 K wrap.
// [R6] Status reset bit resets only its own direction.
// [R7] Reset while active aborts, sets end error, writes that direction's level.
// [R8] Software loads start address bits 3:1 into status bits 2:0 first.
// [R9] Status read returns the direction's completion level and abort flag.
// [R10] Bus abort during transfer sets abort flag, error flag, writes level.
// [R11] Status active bit stands from end write until level is written.
// [R12] Software writes status, then begin, then end to start a transfer.
// [R13] Software checks end bit 15, then bit 0, then status 13 and 8.
// [R14] Ten switches give block base bits 13:4; 19:14 ones, 3:0 zeros.
// [R15] Seven-switch fields per direction give the completion level written.
// [R16] Two switches pick one of four pseudo-interrupt units.
// [R17] Eight device number switches read as low byte of word zero.
// [R18] The register block spans sixteen system bytes.
// [R19] Non-DMA service request writes the level to the pseudo-interrupt unit.
// [R20] Begin write while transferring aborts, flags error, writes level, reinitialises.
// [R21] Begin holds address bits 19:4 and always reads as zero.
// [R22] Word zero reports interface type in high byte; writes do nothing.
// [R23] Receive and transmit keep separate registers and act independently.
`ifndef BDI_DEFS_SVH
`define BDI_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (word index, byte address is four times the index)
// ----------------------------------------------------------------------
`define BDI_IDX_TYPE 3'h0
`define BDI_IDX_RX_BEGIN 3'h1
`define BDI_IDX_RX_END 3'h2
`define BDI_IDX_RX_STAT 3'h3
`define BDI_IDX_TX_BEGIN 3'h4
`define BDI_IDX_TX_END 3'h5
`define BDI_IDX_TX_STAT 3'h6
`define BDI_IDX_DEVDEP 3'h7

// ----------------------------------------------------------------------
// Address decode: system address is bus address bits 20:2 plus a zero
// ----------------------------------------------------------------------
`define BDI_HADDR_TOP_ZERO 11'h000
`define BDI_SYS_HIGH_ONES 6'h3f

// ----------------------------------------------------------------------
// End register fields
// ----------------------------------------------------------------------
`define BDI_END_DONE_BIT 15
`define BDI_END_ERR_BIT 0

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define BDI_ST_RESET_BIT 15
`define BDI_ST_FAULT_BIT 14
`define BDI_ST_ACTIVE_BIT 13
`define BDI_ST_BUS_ABORT_FLAG_BIT 8
`define BDI_ST_FINAL_BIT 3

// ----------------------------------------------------------------------
// Reset values and misc
// ----------------------------------------------------------------------
`define BDI_ZERO16 16'h0000
`define BDI_ZERO12 12'h000
`define BDI_ONE12 12'h001
`define BDI_DEV_TYPE 8'h5a
`define BDI_SW_W 34

`endif

/* rtl/bdi_pkg.sv */
// Types shared by the block-transfer device interface.
// Assumes bdi_defs.svh on the include path.
package bdi_pkg;

   // ----------------------------------------------------------------------
   // Per-direction transfer state, Gray along idle-src-snk-done
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      BDI_S_IDLE = 2'b00,
      BDI_S_SRC = 2'b01,
      BDI_S_SNK = 2'b11,
      BDI_S_DONE = 2'b10
   } bdi_state_e;

   typedef logic [15:0] bdi_word_t;

endpackage : bdi_pkg

/* rtl/bdi_top.sv */
// Block-transfer device interface: AHB-Lite register slave, two DMA
// directions (receive writes memory, transmit reads it) and the
// completion writer toward the pseudo-interrupt unit.
// Assumes one clock, memory ports and device streams on that clock,
// switches and the service request arriving as asynchronous pins.
`timescale 1ns/100ps
`include "bdi_defs.svh"

module bdi_top
   import bdi_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [9:0] addr_sw,
   input wire logic [6:0] rx_level_sw,
   input wire logic [6:0] tx_level_sw,
   input wire logic [1:0] pid_sel_sw,
   input wire logic [7:0] devnum_sw,
   input wire logic svc_ready,
   output logic mem_rx_req,
   output logic [19:0] mem_rx_addr,
   output logic [15:0] mem_rx_wdata,
   input wire logic mem_rx_ack,
   input wire logic mem_rx_abort,
   output logic mem_tx_req,
   output logic [19:0] mem_tx_addr,
   input wire logic [15:0] mem_tx_rdata,
   input wire logic mem_tx_ack,
   input wire logic mem_tx_abort,
   input wire logic rx_valid,
   input wire logic [15:0] rx_data,
   input wire logic rx_last,
   output logic rx_ready,
   output logic tx_valid,
   output logic [15:0] tx_data,
   input wire logic tx_ready,
   input wire logic [1:0] dev_fault,
   output logic pid_wr,
   output logic [1:0] pid_sel,
   output logic [6:0] pid_level,
   output logic [15:0] dev_dep
);

   // ----------------------------------------------------------------------
   // Switch and service-request synchronisers
   // ----------------------------------------------------------------------
   logic [`BDI_SW_W-1:0] sw_m_q;
   logic [`BDI_SW_W-1:0] sw_q;
   logic svc_m_q;
   logic svc_s_q;
   logic svc_old_q;

   // Switches may move at any time; only the second stage is used
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_m_q <= '0;
         sw_q <= '0;
         svc_m_q <= 1'b0;
         svc_s_q <= 1'b0;
         svc_old_q <= 1'b0;
      end else if (ce) begin
         sw_m_q <= {addr_sw, rx_level_sw, tx_level_sw, pid_sel_sw, devnum_sw};
         sw_q <= sw_m_q;
         svc_m_q <= svc_ready;
         svc_s_q <= svc_m_q;
         svc_old_q <= svc_s_q;
      end
   end

   logic [9:0] base_sw;
   logic [6:0] lvl_sw [2];
   logic [1:0] unit_sw;
   logic [7:0] num_sw;
   assign base_sw = sw_q[33:24];
   assign lvl_sw[0] = sw_q[23:17];
   assign lvl_sw[1] = sw_q[16:10];
   assign unit_sw = sw_q[9:8];
   assign num_sw = sw_q[7:0];

   // ----------------------------------------------------------------------
   // AHB-Lite address phase decode
   // ----------------------------------------------------------------------
   wire aph_valid = hsel && htrans[1] && hready;
   // Block base: bits 19:14 ones, 13:4 switches, 3:0 index within block
   wire aph_hit = (haddr[31:21] == `BDI_HADDR_TOP_ZERO)
                  && (haddr[20:15] == `BDI_SYS_HIGH_ONES)
                  && (haddr[14:5] == base_sw); // R14 R18
   wire [2:0] aph_idx = haddr[4:2];

   logic dph_wr_q;
   logic [2:0] dph_idx_q;
   logic [31:0] hrdata_q;
   bdi_word_t rd_word [8];

   // Zero wait state; unmapped reads give zero with an OKAY answer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_q <= 1'b0;
         dph_idx_q <= `BDI_IDX_TYPE;
         hrdata_q <= '0;
      end else if (ce) begin
         dph_wr_q <= aph_valid && aph_hit && hwrite;
         dph_idx_q <= aph_idx;
         hrdata_q <= (aph_valid && aph_hit && !hwrite) ? {16'h0000, rd_word[aph_idx]} : '0;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ----------------------------------------------------------------------
   // Fixed registers: device type word and device-dependent word
   // ----------------------------------------------------------------------
   logic [15:0] devdep_q;
   wire wr_devdep = dph_wr_q && (dph_idx_q == `BDI_IDX_DEVDEP);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         devdep_q <= `BDI_ZERO16;
      end else if (ce && wr_devdep) begin
         devdep_q <= hwdata[15:0];
      end
   end

   // Type word has no write path at all
   assign rd_word[`BDI_IDX_TYPE] = {`BDI_DEV_TYPE, num_sw}; // R17 R22
   assign rd_word[`BDI_IDX_DEVDEP] = devdep_q;
   assign dev_dep = devdep_q;

   // ----------------------------------------------------------------------
   // Completion writer: one pseudo-interrupt write per cycle, rx first
   // ----------------------------------------------------------------------
   logic [1:0] pid_req;
   logic [1:0] pid_gnt;
   logic svc_pend_q;
   logic pid_wr_q;
   logic [1:0] pid_sel_q;
   logic [6:0] pid_level_q;

   assign pid_gnt[0] = pid_req[0];
   assign pid_gnt[1] = pid_req[1] && !pid_req[0];
   wire svc_gnt = svc_pend_q && !pid_req[0] && !pid_req[1];
   wire svc_rise = svc_s_q && !svc_old_q;

   // Service request edge is kept when it meets its own grant
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         svc_pend_q <= 1'b0;
         pid_wr_q <= 1'b0;
         pid_sel_q <= 2'b00;
         pid_level_q <= 7'h00;
      end else if (ce) begin
         svc_pend_q <= svc_rise || (svc_pend_q && !svc_gnt); // R19
         pid_wr_q <= |pid_gnt || svc_gnt;
         pid_sel_q <= unit_sw; // R16
         pid_level_q <= pid_gnt[1] ? lvl_sw[1] : lvl_sw[0]; // R15
      end
   end

   assign pid_wr = pid_wr_q;
   assign pid_sel = pid_sel_q;
   assign pid_level = pid_level_q;

   // ----------------------------------------------------------------------
   // Direction engines: d=0 receive (device to memory), d=1 transmit
   // ----------------------------------------------------------------------
   logic [1:0] mem_req_v;
   logic [19:0] mem_addr_v [2];
   logic [15:0] data_v [2];
   logic [1:0] devflag_v;
   logic [1:0] mem_ack_v;
   logic [1:0] mem_abort_v;
   logic [1:0] dev_ok_v;

   assign mem_ack_v = {mem_tx_ack, mem_rx_ack};
   assign mem_abort_v = {mem_tx_abort, mem_rx_abort};
   assign dev_ok_v = {tx_ready, rx_valid};

   for (genvar d = 0; d < 2; d++) begin : g_dir
      localparam logic [2:0] IB = d ? `BDI_IDX_TX_BEGIN : `BDI_IDX_RX_BEGIN;
      localparam logic [2:0] IE = d ? `BDI_IDX_TX_END : `BDI_IDX_RX_END;
      localparam logic [2:0] IS = d ? `BDI_IDX_TX_STAT : `BDI_IDX_RX_STAT;

      bdi_state_e st_q;
      logic [15:0] begin_q;
      logic [2:0] lowb_q;
      logic final_opt_q;
      logic [11:0] end_q;
      logic [11:0] off_q;
      logic [15:0] data_q;
      logic mem_req_q;
      logic devflag_q;
      logic last_q;
      logic done_q;
      logic err_q;
      logic bus_abort_flag_q;

      // Register decode; each direction only sees its own three words
      wire wr_begin = dph_wr_q && (dph_idx_q == IB);
      wire wr_end = dph_wr_q && (dph_idx_q == IE);
      wire wr_stat = dph_wr_q && (dph_idx_q == IS);
      wire rst_cmd = wr_stat && hwdata[`BDI_ST_RESET_BIT]; // R6
      wire active = (st_q != BDI_S_IDLE); // R11
      wire busy = (st_q == BDI_S_SRC) || (st_q == BDI_S_SNK);
      wire start = wr_end && !active; // R1
      wire bus_abort_flag_ev = mem_req_q && mem_abort_v[d] && busy;
      wire abort = ((wr_begin || rst_cmd) && busy) || bus_abort_flag_ev; // R7 R20 R10
      wire use_dev = (st_q == BDI_S_SRC) == (d == 0);
      wire mem_done = mem_req_q && mem_ack_v[d];
      wire dev_hs = devflag_q && dev_ok_v[d];
      wire adv = busy && !abort && (use_dev ? dev_hs : mem_done);
      wire word_last = (off_q == end_q) || (d == 0 && last_q);
      wire fin_buf = (d == 0) ? last_q : final_opt_q;
      wire fault_ev = dev_fault[d] && active;
      wire err_set = abort || fault_ev; // R3
      wire [11:0] start_off = {begin_q[8:0], lowb_q};

      // Flags: any set in the same cycle as a clear wins
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            err_q <= 1'b0;
            bus_abort_flag_q <= 1'b0;
            done_q <= 1'b0;
         end else if (ce) begin
            err_q <= err_set || (err_q && !start && !(rst_cmd && !active)); // R3
            bus_abort_flag_q <= bus_abort_flag_ev || (bus_abort_flag_q && !start && !(rst_cmd && !active)); // R10
            done_q <= (adv && st_q == BDI_S_SNK && word_last && fin_buf && !err_q)
                      || (done_q && !start && !(rst_cmd && !active)); // R2
         end
      end

      // Software-loaded fields; begin reload also reinitialises
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            begin_q <= `BDI_ZERO16;
            lowb_q <= 3'h0;
            final_opt_q <= 1'b0;
         end else if (ce) begin
            if (wr_begin) begin
               begin_q <= hwdata[15:0]; // R21
            end
            if (wr_stat) begin
               lowb_q <= hwdata[2:0]; // R8
               final_opt_q <= hwdata[`BDI_ST_FINAL_BIT];
            end
         end
      end

      // Transfer sequencer
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            st_q <= BDI_S_IDLE;
            end_q <= `BDI_ZERO12;
            off_q <= `BDI_ZERO12;
            data_q <= `BDI_ZERO16;
            mem_req_q <= 1'b0;
            devflag_q <= 1'b0;
            last_q <= 1'b0;
         end else if (ce) begin
            case (st_q)
               BDI_S_IDLE: begin
                  if (start) begin
                     st_q <= BDI_S_SRC;
                     end_q <= hwdata[12:1];
                     off_q <= start_off; // R1
                     last_q <= 1'b0;
                     mem_req_q <= (d == 1);
                     devflag_q <= (d == 0);
                  end
               end
               BDI_S_SRC, BDI_S_SNK: begin
                  if (abort) begin
                     st_q <= BDI_S_DONE;
                     end_q <= off_q; // R4
                     mem_req_q <= 1'b0;
                     devflag_q <= 1'b0;
                  end else if (adv) begin
                     if (d == 0 && dev_hs) begin
                        data_q <= rx_data;
                        last_q <= rx_last;
                     end
                     if (d == 1 && mem_done) begin
                        data_q <= mem_tx_rdata;
                     end
                     if (st_q == BDI_S_SNK && word_last) begin
                        st_q <= BDI_S_DONE;
                        end_q <= off_q; // R4
                        mem_req_q <= 1'b0;
                        devflag_q <= 1'b0;
                     end else begin
                        st_q <= (st_q == BDI_S_SRC) ? BDI_S_SNK : BDI_S_SRC;
                        mem_req_q <= use_dev;
                        devflag_q <= !use_dev;
                        if (st_q == BDI_S_SNK) begin
                           off_q <= off_q + `BDI_ONE12; // R5
                        end
                     end
                  end
               end
               BDI_S_DONE: begin
                  // Stay active until the level has gone out
                  if (pid_gnt[d]) begin
                     st_q <= BDI_S_IDLE; // R11
                  end
               end
               default: begin
                  st_q <= BDI_S_IDLE;
               end
            endcase
         end
      end

      assign pid_req[d] = (st_q == BDI_S_DONE); // R7 R10 R20
      assign mem_req_v[d] = mem_req_q;
      assign devflag_v[d] = devflag_q;
      assign data_v[d] = data_q;
      // Top seven bits never move, so the buffer wraps inside 8 K bytes
      assign mem_addr_v[d] = {begin_q[15:9], off_q, 1'b0}; // R5

      // Read views; active shows as an error so a stray completion is seen
      assign rd_word[IB] = `BDI_ZERO16; // R21
      assign rd_word[IE] = {done_q, 2'b00, end_q, err_q || active}; // R2 R3 R4
      assign rd_word[IS] = {1'b0, dev_fault[d], active, 4'h0, bus_abort_flag_q, 1'b0,
                            lvl_sw[d]}; // R9 R23
   end

   // ----------------------------------------------------------------------
   // Port fan-out, all taken from direction flip-flops
   // ----------------------------------------------------------------------
   assign mem_rx_req = mem_req_v[0];
   assign mem_rx_addr = mem_addr_v[0];
   assign mem_rx_wdata = data_v[0];
   assign rx_ready = devflag_v[0];
   assign mem_tx_req = mem_req_v[1];
   assign mem_tx_addr = mem_addr_v[1];
   assign tx_valid = devflag_v[1];
   assign tx_data = data_v[1];

   // Unused on a word-only slave
   wire unused_ok = &{1'b0, hsize, hwdata[31:16]};

endmodule : bdi_top

/* bench/bdi_mem_model.sv */
// Memory side of the block-transfer device: answers both memory ports.
// Assumes each request is held until its ack or abort pulse.
`timescale 1ns/100ps
module bdi_mem_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] lat,
   input wire logic bus_abort_flag,
   input wire logic mem_rx_req,
   input wire logic [19:0] mem_rx_addr,
   input wire logic [15:0] mem_rx_wdata,
   output logic mem_rx_ack,
   output logic mem_rx_abort,
   input wire logic mem_tx_req,
   input wire logic [19:0] mem_tx_addr,
   output logic [15:0] mem_tx_rdata,
   output logic mem_tx_ack,
   output logic mem_tx_abort,
   output logic [35:0] last_wr
);
   // --------------------
   // Answer timing
   // --------------------
   logic [3:0] rcnt_q, tcnt_q;
   logic rgo, tgo;
   logic [15:0] tpat;
   // One answer per request, after lat waiting cycles
   assign rgo = mem_rx_req && !mem_rx_ack && !mem_rx_abort && rcnt_q == lat;
   assign tgo = mem_tx_req && !mem_tx_ack && !mem_tx_abort && tcnt_q == lat;
   assign tpat = mem_tx_addr[16:1] ^ {mem_tx_addr[19:17], 13'h0b5};
   // Read data toggles outside the ack cycle so stale data never matches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {rcnt_q, tcnt_q} <= 8'h00;
         {mem_rx_ack, mem_rx_abort, mem_tx_ack, mem_tx_abort} <= 4'h0;
         mem_tx_rdata <= 16'h0000;
         last_wr <= 36'h0;
      end else begin
         rcnt_q <= mem_rx_req ? rcnt_q + 4'h1 : 4'h0;
         tcnt_q <= mem_tx_req ? tcnt_q + 4'h1 : 4'h0;
         mem_rx_ack <= rgo && !bus_abort_flag;
         mem_rx_abort <= rgo && bus_abort_flag;
         mem_tx_ack <= tgo && !bus_abort_flag;
         mem_tx_abort <= tgo && bus_abort_flag;
         mem_tx_rdata <= tgo ? tpat : ~mem_tx_rdata;
         if (mem_rx_ack) last_wr <= {mem_rx_addr, mem_rx_wdata};
      end
   end
endmodule : bdi_mem_model

/* bench/bdi_top_assertions.sv */
// Port-level checks of the block-transfer device interface.
// Assumes ce tied high and switches steady once reset is released.
`timescale 1ns/100ps
`include "bdi_defs.svh"
module bdi_top_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [9:0] addr_sw,
   input wire logic [6:0] rx_level_sw,
   input wire logic [6:0] tx_level_sw,
   input wire logic [1:0] pid_sel_sw,
   input wire logic [7:0] devnum_sw,
   input wire logic mem_rx_req,
   input wire logic [19:0] mem_rx_addr,
   input wire logic [15:0] mem_rx_wdata,
   input wire logic mem_rx_ack,
   input wire logic mem_rx_abort,
   input wire logic rx_valid,
   input wire logic [15:0] rx_data,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [15:0] tx_data,
   input wire logic tx_ready,
   input wire logic pid_wr,
   input wire logic [1:0] pid_sel,
   input wire logic [6:0] pid_level
);
   // --------------------
   // Read decode seen from outside
   // --------------------
   logic take, hit;
   // Reads only; hrdata must be zero after anything else
   assign take = hsel && htrans[1] && hready && !hwrite;
   assign hit = haddr[31:15] == {11'h000, 6'h3f} && haddr[14:5] == addr_sw;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   property p_type; take && hit && haddr[4:2] == 3'h0
      |=> hrdata == {16'h0000, `BDI_DEV_TYPE, devnum_sw}; endproperty
   a_type: assert property (p_type) else $error("type word wrong");
   property p_miss; take && !hit |=> hrdata == 32'h0; endproperty
   a_miss: assert property (p_miss) else $error("foreign address answered");
   property p_begin; take && haddr[4:2] inside {3'h1, 3'h4} |=> hrdata == 32'h0; endproperty
   a_begin: assert property (p_begin) else $error("begin read not zero");
   property p_stat; take && hit && haddr[4:2] == 3'h3 |=> hrdata[6:0] == rx_level_sw; endproperty
   a_stat: assert property (p_stat) else $error("status level wrong");
   property p_lvl; pid_wr |-> pid_level == rx_level_sw || pid_level == tx_level_sw; endproperty
   a_lvl: assert property (p_lvl) else $error("completion level wrong");
   property p_sel; pid_wr |-> pid_sel == pid_sel_sw; endproperty
   a_sel: assert property (p_sel) else $error("unit select wrong");
   // A software abort in the same cycle drops the word; its level follows
   property p_take; rx_valid && rx_ready
      |=> (!rx_ready && mem_rx_req && mem_rx_wdata == $past(rx_data)) or ##1 pid_wr;
   endproperty
   a_take: assert property (p_take) else $error("rx word not stored");
   property p_hold; mem_rx_req && !mem_rx_ack && !mem_rx_abort
      |=> (mem_rx_req && $stable(mem_rx_addr)) or ##1 pid_wr; endproperty
   a_hold: assert property (p_hold) else $error("rx request dropped");
   property p_txh; tx_valid && !tx_ready
      |=> (tx_valid && $stable(tx_data)) or (##[0:2] pid_wr); endproperty
   a_txh: assert property (p_txh) else $error("tx word dropped");
   property p_bus_abort_flag; mem_rx_req && mem_rx_abort
      |-> ##[1:3] (pid_wr && pid_level == rx_level_sw); endproperty
   a_bus_abort_flag: assert property (p_bus_abort_flag) else $error("no level after abort");
endmodule : bdi_top_checker
bind bdi_top bdi_top_checker u_chk (.*);

/* bench/testbench.sv */
// Directed bench for the block-transfer device interface.
// Assumes the memory model on the far side and a zero-wait slave.
`timescale 1ns/100ps
`include "bdi_defs.svh"
module testbench;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, svc_ready, bus_abort_flag;
   logic rx_valid, rx_last, rx_ready, tx_valid, tx_ready, pid_wr;
   logic mem_rx_req, mem_rx_ack, mem_rx_abort, mem_tx_req, mem_tx_ack, mem_tx_abort;
   logic [1:0] htrans, dev_fault, pid_sel;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [19:0] mem_rx_addr, mem_tx_addr;
   logic [15:0] mem_rx_wdata, mem_tx_rdata, rx_data, tx_data, dev_dep;
   logic [35:0] last_wr;
   logic [6:0] pid_level;
   logic [9:0] addr_sw = 10'h2b5;
   logic [6:0] rx_level_sw = 7'h45;
   logic [6:0] tx_level_sw = 7'h1a;
   logic [7:0] devnum_sw = 8'h9c;
   logic [1:0] pid_sel_sw = 2'h2;
   logic [3:0] lat = 4'h2;
   int error_cnt = 0;
   int n_checks = 0;
   bdi_top DUT (.*, .ce(1'b1), .hsize(3'h2), .hready(hreadyout));
   bdi_mem_model u_mem (.*);
   // --------------------
   // Shared tasks
   // --------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [31:0] ra(input logic [2:0] i);
      return {11'h000, 6'h3f, addr_sw, i, 2'b00};
   endfunction : ra
   // Memory contents as the far side serves them
   function automatic logic [15:0] pat(input logic [19:0] a);
      return a[16:1] ^ {a[19:17], 13'h0b5};
   endfunction : pat
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      v = hrdata;
      hsel <= 1'b0;
   endtask : bus
   task automatic wr(input logic [2:0] i, input logic [15:0] d);
      bus(1'b1, ra(i), {16'h0000, d});
   endtask : wr
   task automatic rd(input logic [2:0] i, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, ra(i), 32'h0);
      chk(v & m, e);
   endtask : rd
   task automatic rx_push(input logic [15:0] d);
      rx_valid <= 1'b1;
      rx_data <= d;
      rx_last <= 1'b1;
      do @(posedge hclk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      rx_data <= ~d;
   endtask : rx_push
   // Sink stalls a few cycles before taking each word
   task automatic tx_pull(input logic [19:0] a);
      repeat (3) @(posedge hclk);
      tx_ready <= 1'b1;
      do @(posedge hclk); while (tx_valid !== 1'b1);
      chk({16'h0000, tx_data}, {16'h0000, pat(a)});
      tx_ready <= 1'b0;
   endtask : tx_pull
   task automatic wait_pid(input logic [6:0] lvl);
      int k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (pid_wr !== 1'b1 && k < 300);
      chk({22'h0, pid_wr, pid_sel, pid_level}, {22'h0, 1'b1, pid_sel_sw, lvl});
   endtask : wait_pid
   // --------------------
   // Scenarios
   // --------------------
   task automatic t_regs;
      wr(3'h0, 16'hffff);
      rd(3'h0, '1, {16'h0000, `BDI_DEV_TYPE, devnum_sw});
      wr(3'h1, 16'h1234);
      rd(3'h1, '1, 32'h0);
      dev_fault <= 2'b01;
      rd(3'h3, 32'h617f, {17'h0, 1'b1, 7'h00, rx_level_sw});
      dev_fault <= 2'b00;
      rd(3'h6, 32'h617f, {25'h0, tx_level_sw});
      wr(3'h7, 16'hc3a5);
      bus(1'b1, ra(3'h7) ^ 32'h20, 32'hffff);
      bus(1'b0, ra(3'h7) ^ 32'h8000, 32'h0);
      chk(v, 32'h0);
      rd(3'h7, '1, 32'hc3a5);
      chk({16'h0000, dev_dep}, 32'hc3a5);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_rx;
      wr(3'h3, 16'h0005);
      wr(3'h1, 16'hfe01);
      wr(3'h2, 16'h001a);
      rd(3'h3, 32'h2000, 32'h2000);
      rd(3'h2, 32'h1, 32'h1);
      rx_push(16'h7e3c);
      wait_pid(rx_level_sw);
      chk({12'h000, last_wr[35:16]}, 32'hfe01a);
      chk({16'h0000, last_wr[15:0]}, 32'h7e3c);
      rd(3'h2, '1, 32'h801a);
      rd(3'h3, 32'h2000, 32'h0);
      $display("t_rx done");
   endtask : t_rx
   task automatic t_tx;
      lat <= 4'h0;
      wr(3'h6, 16'h0007);
      wr(3'h4, 16'h81ff);
      wr(3'h5, 16'h0000);
      tx_pull(20'h81ffe);
      tx_pull(20'h80000);
      wait_pid(tx_level_sw);
      rd(3'h5, 32'hffff9fff, 32'h0);
      $display("t_tx done");
   endtask : t_tx
   task automatic t_abort;
      wr(3'h6, 16'h0000);
      wr(3'h4, 16'h8000);
      wr(3'h5, 16'h0000);
      wr(3'h3, 16'h0000);
      wr(3'h1, 16'hfe00);
      wr(3'h2, 16'h0000);
      wr(3'h6, 16'h8000);
      wait_pid(tx_level_sw);
      rd(3'h5, 32'h1, 32'h1);
      rd(3'h3, 32'h2000, 32'h2000);
      wr(3'h1, 16'hfe00);
      wait_pid(rx_level_sw);
      rd(3'h2, 32'h8001, 32'h1);
      bus_abort_flag <= 1'b1;
      wr(3'h2, 16'h0000);
      rx_push(16'h1111);
      wait_pid(rx_level_sw);
      bus_abort_flag <= 1'b0;
      rd(3'h2, 32'h8001, 32'h1);
      rd(3'h3, 32'h2100, 32'h0100);
      wr(3'h3, 16'h8000);
      rd(3'h3, 32'h0100, 32'h0);
      svc_ready <= 1'b1;
      wait_pid(rx_level_sw);
      svc_ready <= 1'b0;
      $display("t_abort done");
   endtask : t_abort
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   // Free-running 100 MHz clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Whole run is a few hundred cycles; this catches a hung handshake
   initial begin
      #200us;
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      finish_test();
   end
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, svc_ready, bus_abort_flag, rx_valid, rx_last, tx_ready} = 7'h00;
      {htrans, dev_fault} = 4'h0;
      {haddr, hwdata} = 64'h0;
      rx_data = 16'h0000;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      t_regs();
      t_rx();
      t_tx();
      t_abort();
      finish_test();
   end
endmodule : testbench
